// ===== logic/spm_map.vh
// Register map, field positions and divider counts of the SPI port.
// Assumes a 32-bit APB word per register and pclk as the oscillator.
`ifndef SPM_MAP_VH
`define SPM_MAP_VH

`define SPM_OFF_STATUS   12'h000
`define SPM_OFF_CONTROL  12'h004
`define SPM_OFF_DATA     12'h008
`define SPM_OFF_IRQFLAG  12'h00C

`define SPM_ST_SMP       7
`define SPM_ST_CKE       6
`define SPM_ST_STOP      4
`define SPM_ST_BF        0

`define SPM_CT_WRITE_COLLISION_FLAG      7
`define SPM_CT_OV        6
`define SPM_CT_EN        5
`define SPM_CT_CKP       4

`define SPM_MODE_DIV4    4'h0
`define SPM_MODE_DIV16   4'h1
`define SPM_MODE_DIV64   4'h2
`define SPM_MODE_TMR     4'h3
`define SPM_MODE_SLV_SS  4'h4
`define SPM_MODE_SLV     4'h5

`define SPM_RST_STATUS   8'h00
`define SPM_RST_CONTROL  8'h00

// Half bit periods in pclk cycles
`define SPM_HALF_DIV4    5'h02
`define SPM_HALF_DIV16   5'h08
`define SPM_HALF_DIV64   5'h20

// Clock edges per word in master operation
`define SPM_EDGES        5'h10

`endif

// ===== logic/spm_clkdiv.v
// Half bit period tick generator for master operation.
// Assumes run restarts the count; timer pulses are one pclk wide.
`timescale 1ns/1ns
`default_nettype none
`include "spm_map.vh"

module spm_clkdiv (
	input  wire       pclk,
	input  wire       presetn,
	input  wire       run,
	input  wire [1:0] sel,
	input  wire       timer_two_output,
	output reg        tick_r
);

	reg  [4:0] cnt_r;
	reg  [4:0] half;

	always @* begin
		case (sel)
			2'h0:    half = `SPM_HALF_DIV4;
			2'h1:    half = `SPM_HALF_DIV16;
			default: half = `SPM_HALF_DIV64;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r  <= 5'h00;
			tick_r <= 1'b0;
		end else if (!run) begin
			cnt_r  <= 5'h00;
			tick_r <= 1'b0;
		end else if (sel == 2'h3) begin
			// Timer output used directly: each pulse is half a bit clock
			tick_r <= timer_two_output;
		end else if (cnt_r == half - 5'h01) begin
			cnt_r  <= 5'h00;
			tick_r <= 1'b1;
		end else begin
			cnt_r  <= cnt_r + 5'h01;
			tick_r <= 1'b0;
		end
	end

endmodule // spm_clkdiv

`default_nettype wire

// ===== logic/spm_port.v
// SPI master/slave port with APB register access.
// Assumes synchronous pins; the bench resolves sck and sdo from enables.
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "spm_map.vh"

module spm_port #(
	parameter WORD_W = 8
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata_r,
	output reg         pready_r,
	output reg         pslverr_r,
	input  wire        sck_in,
	output reg         sck_out_r,
	output reg         sck_oe_r,
	input  wire        sdi_in,
	output reg         sdo_out_r,
	output reg         sdo_oe_r,
	input  wire        ss_n_in,
	output reg         pins_to_port_r,
	output reg         ss_pin_to_port_r,
	input  wire        timer_two_output
);

	localparam ST_OFF   = 2'h0;
	localparam ST_MIDLE = 2'h1;
	localparam ST_MBUSY = 2'h2;
	localparam ST_SLAVE = 2'h3;

	function [2:0] dec_reg;
		input [11:0] a;
		begin
			case (a)
				`SPM_OFF_STATUS:  dec_reg = 3'h0;
				`SPM_OFF_CONTROL: dec_reg = 3'h1;
				`SPM_OFF_DATA:    dec_reg = 3'h2;
				`SPM_OFF_IRQFLAG: dec_reg = 3'h3;
				default:          dec_reg = 3'h4;
			endcase
		end
	endfunction

	reg  [1:0]        state_r;
	reg  [1:0]        stat_hi_r;
	reg               write_collision_flag_r;
	reg               ov_r;
	reg               en_r;
	reg               ckp_r;
	reg  [3:0]        mode_r;
	reg               bf_r;
	reg               irq_flag_r;
	reg  [WORD_W-1:0] buf_r;
	reg  [WORD_W-1:0] tx_sr_r;
	reg  [WORD_W-1:0] rx_sr_r;
	reg  [3:0]        scnt_r;
	reg  [4:0]        t_r;
	reg               sck_r;
	reg               sck_q_r;

	wire       sample_select  = stat_hi_r[1];
	wire       cke  = stat_hi_r[0];
	wire       master = en_r && (mode_r[3:2] == 2'h0);
	wire       slave  = en_r && (mode_r == `SPM_MODE_SLV_SS || mode_r == `SPM_MODE_SLV);
	wire       ss_used = (mode_r == `SPM_MODE_SLV_SS);
	wire       ss_hold = ss_used && ss_n_in;

	// APB handshake: answer one cycle into the access phase
	wire       acc  = psel && penable && !pready_r;
	wire       done = psel && penable && pready_r;
	wire [2:0] rsel = dec_reg(paddr);
	wire       wr   = done && pwrite;
	wire       rd   = done && !pwrite;
	wire       wr_stat = wr && rsel == 3'h0;
	wire       wr_ctrl = wr && rsel == 3'h1;
	wire       wr_data = wr && rsel == 3'h2;
	wire       wr_irq  = wr && rsel == 3'h3;
	wire       rd_data = rd && rsel == 3'h2;

	// Shifting in progress blocks data writes
	wire       shifting = (state_r == ST_MBUSY) ||
	                      (state_r == ST_SLAVE && scnt_r != 4'h0);
	wire       can_load = (state_r == ST_MIDLE) || (state_r == ST_SLAVE && !shifting);
	wire       tx_load  = wr_data && can_load;
	wire       write_collision_flag_set = wr_data && shifting;

	// Master timing
	wire       tick;
	wire [4:0] t_nxt = t_r + 5'h01;
	wire       m_tick = (state_r == ST_MBUSY) && tick;
	wire       m_out  = m_tick && t_nxt < `SPM_EDGES && (t_nxt[0] == ~cke);
	wire       m_samp = m_tick && scnt_r != WORD_W[3:0] &&
	                    (t_nxt[0] == (cke ^ sample_select)) &&
	                    !(!cke && sample_select && t_nxt == 5'h01);

	// Slave edges taken from the pin as seen last cycle
	wire       lead  = (sck_q_r == ckp_r) && (sck_in != ckp_r);
	wire       trail = (sck_q_r != ckp_r) && (sck_in == ckp_r);
	wire       s_act = (state_r == ST_SLAVE) && !ss_hold;
	wire       s_out  = s_act && (cke ? trail : lead);
	wire       s_samp = s_act && (cke ? lead : trail);

	wire       samp   = m_samp || s_samp;
	wire       shout  = m_out || s_out;
	wire [3:0] scnt_inc = scnt_r + 4'h1;
	wire       word_done = samp && scnt_inc == WORD_W[3:0];
	wire [WORD_W-1:0] rx_word = {rx_sr_r[WORD_W-2:0], sdi_in};
	wire       m_end  = m_tick && t_nxt >= `SPM_EDGES &&
	                    (scnt_r == WORD_W[3:0] || word_done);
	wire       ov_set = word_done && slave && bf_r;
	wire       rx_take = word_done && !(slave && bf_r);

	spm_clkdiv u_div (
		.pclk             (pclk),
		.presetn          (presetn),
		.run              (state_r == ST_MBUSY),
		.sel              (mode_r[1:0]),
		.timer_two_output (timer_two_output),
		.tick_r           (tick)
	);

	// APB answer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			prdata_r  <= 32'h00000000;
			pslverr_r <= 1'b0;
		end else begin
			pready_r  <= acc;
			pslverr_r <= acc && rsel == 3'h4;
			if (acc) begin
				case (rsel)
					3'h0: prdata_r <= {24'h000000, stat_hi_r, 1'b0,
					                    1'b0, 3'h0, bf_r};
					3'h1: prdata_r <= {24'h000000, write_collision_flag_r, ov_r, en_r,
					                    ckp_r, mode_r};
					3'h2: prdata_r <= {{(32-WORD_W){1'b0}}, buf_r};
					3'h3: prdata_r <= {31'h00000000, irq_flag_r};
					default: prdata_r <= 32'h00000000;
				endcase
			end else begin
				prdata_r <= 32'h00000000;
			end
		end
	end

	// Configuration and flags; hardware set wins over software clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_hi_r  <= 2'h0;
			write_collision_flag_r     <= 1'b0;
			ov_r       <= 1'b0;
			en_r       <= 1'b0;
			ckp_r      <= 1'b0;
			mode_r     <= 4'h0;
			bf_r       <= 1'b0;
			irq_flag_r <= 1'b0;
		end else begin
			if (wr_stat)
				stat_hi_r <= pwdata[`SPM_ST_SMP:`SPM_ST_CKE];
			if (wr_ctrl) begin
				en_r   <= pwdata[`SPM_CT_EN];
				ckp_r  <= pwdata[`SPM_CT_CKP];
				mode_r <= pwdata[3:0];
			end
			if (write_collision_flag_set)
				write_collision_flag_r <= 1'b1;
			else if (wr_ctrl)
				write_collision_flag_r <= pwdata[`SPM_CT_WRITE_COLLISION_FLAG];
			if (ov_set)
				ov_r <= 1'b1;
			else if (wr_ctrl)
				ov_r <= pwdata[`SPM_CT_OV];
			if (rx_take)
				bf_r <= 1'b1;
			else if (rd_data)
				bf_r <= 1'b0;
			if (word_done)
				irq_flag_r <= 1'b1;
			else if (wr_irq)
				irq_flag_r <= pwdata[0];
		end
	end

	// Engine state
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_OFF;
		end else if (!en_r) begin
			state_r <= ST_OFF;
		end else begin
			case (state_r)
				ST_OFF:   state_r <= master ? ST_MIDLE : (slave ? ST_SLAVE : ST_OFF);
				ST_MIDLE: begin
					if (!master)
						state_r <= ST_OFF;
					else if (tx_load)
						state_r <= ST_MBUSY;
				end
				ST_MBUSY: begin
					if (m_end)
						state_r <= ST_MIDLE;
				end
				ST_SLAVE: begin
					if (!slave)
						state_r <= ST_OFF;
				end
				default:  state_r <= ST_OFF;
			endcase
		end
	end

	// Shift registers, counters and the data buffer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buf_r   <= {WORD_W{1'b0}};
			tx_sr_r <= {WORD_W{1'b0}};
			rx_sr_r <= {WORD_W{1'b0}};
			scnt_r  <= 4'h0;
			t_r     <= 5'h00;
			sck_q_r <= 1'b0;
		end else begin
			sck_q_r <= sck_in;
			if (tx_load)
				buf_r <= pwdata[WORD_W-1:0];
			else if (rx_take)
				buf_r <= rx_word;
			if (state_r == ST_OFF || ss_hold) begin
				scnt_r <= 4'h0;
				t_r    <= 5'h00;
			end else begin
				if (tx_load) begin
					tx_sr_r <= cke ? {pwdata[WORD_W-2:0], 1'b0} : pwdata[WORD_W-1:0];
					t_r     <= 5'h00;
					scnt_r  <= 4'h0;
				end else begin
					if (shout)
						tx_sr_r <= {tx_sr_r[WORD_W-2:0], 1'b0};
					if (m_tick)
						t_r <= t_nxt;
					if (samp) begin
						rx_sr_r <= rx_word;
						scnt_r  <= (slave && word_done) ? 4'h0 : scnt_inc;
					end
				end
			end
		end
	end

	// Pins, all from flip-flops
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_r            <= 1'b0;
			sck_out_r        <= 1'b0;
			sck_oe_r         <= 1'b0;
			sdo_out_r        <= 1'b0;
			sdo_oe_r         <= 1'b0;
			pins_to_port_r   <= 1'b0;
			ss_pin_to_port_r <= 1'b0;
		end else begin
			if (state_r != ST_MBUSY)
				sck_r <= ckp_r;
			else if (m_tick && t_r < `SPM_EDGES)
				sck_r <= ~sck_r;
			sck_out_r <= (state_r == ST_MBUSY) ? sck_r : ckp_r;
			sck_oe_r  <= master;
			if (tx_load)
				sdo_out_r <= pwdata[WORD_W-1];
			else if (shout)
				sdo_out_r <= tx_sr_r[WORD_W-1];
			sdo_oe_r         <= master || (slave && !ss_hold);
			pins_to_port_r   <= en_r;
			ss_pin_to_port_r <= en_r && ss_used;
		end
	end

endmodule // spm_port

`default_nettype wire

// ===== test/spm_port_sva.sv
// Checker for the SPI port handshake and pin ownership.
// Assumes a bind to spm_port in the pclk domain.
`timescale 1ns/1ns
`default_nettype none
module spm_port_sva (
	input wire logic	pclk,
	input wire logic	presetn,
	input wire logic	psel,
	input wire logic	penable,
	input wire logic	pwrite,
	input wire logic [11:0]	paddr,
	input wire logic [31:0]	pwdata,
	input wire logic [31:0]	prdata_r,
	input wire logic	pready_r,
	input wire logic	pslverr_r,
	input wire logic	sck_in,
	input wire logic	sck_out_r,
	input wire logic	sck_oe_r,
	input wire logic	sdi_in,
	input wire logic	sdo_out_r,
	input wire logic	sdo_oe_r,
	input wire logic	ss_n_in,
	input wire logic	pins_to_port_r,
	input wire logic	ss_pin_to_port_r,
	input wire logic	timer_two_output
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence apb_setup;
		psel && !penable;
	endsequence
	sequence apb_access;
		psel && penable;
	endsequence
	ready_wait_a: assert property (apb_setup ##1 apb_access |-> !pready_r ##1 pready_r)
		else $error("ready not in second access cycle");
	ready_pulse_a: assert property (pready_r |=> !pready_r)
		else $error("ready longer than one cycle");
	unmapped_err_a: assert property (pready_r |-> pslverr_r == (paddr > 12'h00C))
		else $error("error response wrong");
	word_width_a: assert property (pready_r && !pwrite |-> prdata_r[31:8] == 24'h0)
		else $error("read data above the word");
	sck_half_a: assert property ($changed(sck_out_r) && sck_oe_r |=> $stable(sck_out_r))
		else $error("serial clock half period too short");
	ss_release_a: assert property (ss_pin_to_port_r && ss_n_in ##1 ss_pin_to_port_r |-> !sdo_oe_r)
		else $error("data out driven while deselected");
	pins_off_a: assert property (!pins_to_port_r [*2] |-> !sck_oe_r && !sdo_oe_r)
		else $error("pin driven while disabled");
	master_only_a: assert property (sck_oe_r |-> pins_to_port_r && !ss_pin_to_port_r)
		else $error("clock driven outside master");
endmodule // spm_port_sva
bind spm_port spm_port_sva u_spm_port_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata_r, .pready_r, .pslverr_r, .sck_in, .sck_out_r, .sck_oe_r, .sdi_in,
	.sdo_out_r, .sdo_oe_r, .ss_n_in, .pins_to_port_r, .ss_pin_to_port_r, .timer_two_output);
`default_nettype wire

// ===== test/spm_peer.sv
// Far-side SPI device: slave to a master port, master to a slave port.
// Assumes edge select set: data changes on trailing, sampled on leading.
`timescale 1ns/1ns
`default_nettype none
module spm_peer (
	input wire logic	pclk,
	input wire logic	cpol,
	input wire logic	load,
	input wire logic [7:0]	tx_byte,
	input wire logic	go,
	input wire logic	sck,
	input wire logic	mosi,
	output logic		miso,
	output logic		sck_drv,
	output logic [7:0]	rx_byte,
	output logic		busy
);
	logic [7:0]	sh_r;
	logic [3:0]	div_r;
	logic [4:0]	edges_r;
	logic		sck_d;
	logic		tgl_r;
	initial begin
		{sh_r, rx_byte, div_r, edges_r, sck_d, tgl_r, busy} = '0;
	end
	assign miso = sh_r[7];
	assign sck_drv = tgl_r ^ cpol;
	// Shifts on the pin edge itself, as a real device would
	always @(posedge pclk or posedge sck or negedge sck) begin
		if (sck != sck_d) begin
			sck_d <= sck;
			if (sck_d == cpol)
				rx_byte <= {rx_byte[6:0], mosi};
			else
				sh_r <= {sh_r[6:0], ~sh_r[0]};
		end else if (load) begin
			sh_r <= tx_byte;
		end
	end
	always @(posedge pclk) begin
		if (go) begin
			busy <= 1'b1;
			div_r <= 4'h0;
			edges_r <= 5'h00;
		end else if (busy) begin
			div_r <= div_r + 4'h1;
			if (div_r == 4'h7) begin
				div_r <= 4'h0;
				tgl_r <= ~tgl_r;
				edges_r <= edges_r + 5'h01;
				busy <= (edges_r != 5'h0F);
			end
		end
	end
endmodule // spm_peer
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench for the SPI port over APB.
// Assumes spm_port, spm_peer and the register map header.
`timescale 1ns/1ns
`default_nettype none
`include "spm_map.vh"
module tb_top;
	logic		pclk, presetn, psel, penable, pwrite, tmr, ss_n_in, load, go, cpol, busy;
	logic		pready_r, pslverr_r, sck_out_r, sck_oe_r, sdo_out_r, sdo_oe_r, p_sck, sdi_in;
	logic		pins_to_port_r, ss_pin_to_port_r;
	logic [11:0]	paddr;
	logic [31:0]	pwdata, prdata_r, q;
	logic [7:0]	ptx, prx;
	logic [1:0]	tcnt;
	int		failures, comparisons, m, w;
	wire logic	sck_in = sck_oe_r ? sck_out_r : p_sck;
	wire logic	mosi = sdo_oe_r ? sdo_out_r : 1'b1;
	spm_port u_spm_port (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata_r, .pready_r, .pslverr_r, .sck_in, .sck_out_r, .sck_oe_r, .sdi_in,
		.sdo_out_r, .sdo_oe_r, .ss_n_in, .pins_to_port_r, .ss_pin_to_port_r,
		.timer_two_output(tmr));
	spm_peer u_spm_peer (.pclk, .cpol, .load, .tx_byte(ptx), .go, .sck(sck_in), .mosi,
		.miso(sdi_in), .sck_drv(p_sck), .rx_byte(prx), .busy);
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (!presetn) begin
			tcnt <= 2'h0;
			tmr <= 1'b0;
		end else begin
			tcnt <= (tcnt == 2'h2) ? 2'h0 : tcnt + 2'h1;
			tmr <= (tcnt == 2'h1);
		end
	end
	task automatic final_report();
		if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready_r !== 1'b1 && n < 20);
		q = prdata_r;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			failures++;
			final_report();
		end
		@(posedge pclk);
	endtask
	task automatic rd(input logic [11:0] a, input string nm, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(nm, q, exp);
	endtask
	task automatic peer_load(input logic [7:0] t, input logic g);
		int n;
		ptx <= t;
		load <= 1'b1;
		go <= g;
		@(posedge pclk);
		load <= 1'b0;
		go <= 1'b0;
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (busy && n < 400);
		if (n >= 400) begin
			failures++;
			final_report();
		end
		@(posedge pclk);
	endtask
	initial begin
		{psel, penable, pwrite, load, go, cpol} = '0;
		{paddr, pwdata, ptx} = '0;
		ss_n_in = 1'b1;
		failures = 0;
		comparisons = 0;
		presetn = 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(`SPM_OFF_STATUS, "status", 32'h0);
		rd(`SPM_OFF_CONTROL, "control", 32'h0);
		apb(1'b1, `SPM_OFF_STATUS, 32'hFF);
		rd(`SPM_OFF_STATUS, "status", 32'hC0);
		rd(12'h010, "unmapped", 32'h0);
		for (m = 0; m < 4; m++) begin
			cpol <= m[0];
			apb(1'b1, `SPM_OFF_STATUS, {24'h0, m[0], 7'h40});
			apb(1'b1, `SPM_OFF_CONTROL, 32'h20 | {m[0], m[3:0]});
			peer_load(8'h3C + m[7:0], 1'b0);
			check("sck idle", sck_in, m[0]);
			apb(1'b1, `SPM_OFF_DATA, 32'hA5 ^ m);
			apb(1'b1, `SPM_OFF_DATA, 32'h11);
			rd(`SPM_OFF_CONTROL, "control", 32'hA0 | {m[0], m[3:0]});
			apb(1'b0, `SPM_OFF_STATUS, 32'h0);
			w = 0;
			while (q[0] !== 1'b1 && w < 300) begin
				apb(1'b0, `SPM_OFF_STATUS, 32'h0);
				w++;
			end
			if (w >= 300) begin
				failures++;
				final_report();
			end
			rd(`SPM_OFF_DATA, "rx", 32'h3C + m);
			check("peer", prx, 32'hA5 ^ m);
			rd(`SPM_OFF_STATUS, "status", {24'h0, m[0], 7'h40});
		end
		cpol <= 1'b0;
		apb(1'b1, `SPM_OFF_STATUS, 32'h40);
		apb(1'b1, `SPM_OFF_CONTROL, 32'h24);
		ss_n_in <= 1'b0;
		apb(1'b1, `SPM_OFF_DATA, 32'h96);
		peer_load(8'h5A, 1'b1);
		rd(`SPM_OFF_STATUS, "status", 32'h41);
		rd(`SPM_OFF_IRQFLAG, "irq", 32'h1);
		check("peer", prx, 32'h96);
		peer_load(8'hC3, 1'b1);
		rd(`SPM_OFF_CONTROL, "control", 32'h64);
		rd(`SPM_OFF_DATA, "rx", 32'h5A);
		ss_n_in <= 1'b1;
		apb(1'b1, `SPM_OFF_CONTROL, 32'h25);
		rd(`SPM_OFF_CONTROL, "control", 32'h25);
		apb(1'b1, `SPM_OFF_CONTROL, 32'h0);
		rd(`SPM_OFF_STATUS, "status", 32'h40);
		final_report();
	end
endmodule // tb_top
`default_nettype wire
